// ==== can_pkg.sv ====
// Constants for the CAN buffer, status and bit timing block
package can_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TIM = 8'h04;
	localparam logic [7:0] A_INTF = 8'h08;
	localparam logic [7:0] A_ERRCNT = 8'h0c;
	localparam logic [7:0] A_FILT0 = 8'h10;
	localparam logic [7:0] A_FILT1 = 8'h14;
	localparam logic [7:0] A_MASK0 = 8'h18;
	localparam logic [7:0] A_MASK1 = 8'h1c;
	localparam logic [7:0] A_TXCON0 = 8'h20;
	localparam logic [7:0] A_RECEIVE_BUFFER_ZERO = 8'h30;
	localparam logic [7:0] A_RECEIVE_BUFFER_ONE = 8'h34;
	localparam logic [7:0] A_TXB = 8'h40;
	localparam logic [7:0] A_TXB_END = 8'h6f;
	localparam int CTRL_DOUBLE_BUFFER_ENABLE = 0;
	localparam int CTRL_CKS = 1;
	localparam int CTRL_ABORT_ALL_PENDING = 12;
	localparam logic [31:0] TIM_MASK = 32'h0007_773f;
	localparam int F_RX0 = 0;
	localparam int F_RX1 = 1;
	localparam int F_TX0 = 2;
	localparam int F_ERR = 5;
	localparam int F_WAK = 6;
	localparam int F_IVR = 7;
	localparam int F_RX_WARNING_FLAG = 9;
	localparam int F_TX_WARNING_FLAG = 10;
	localparam int F_RX_ERROR_PASSIVE_FLAG = 11;
	localparam int F_TX_ERROR_PASSIVE_FLAG = 12;
	localparam int F_BO = 13;
	localparam int F_OVR1 = 14;
	localparam int F_OVR0 = 15;
	localparam int C_IE = 2;
	localparam int C_REQ = 3;
	localparam int C_ERR = 4;
	localparam int C_LARB = 5;
	localparam int C_ABT = 6;
	localparam logic [8:0] WARN_LIM = 9'h060;
	localparam logic [8:0] PASS_LIM = 9'h07f;
	localparam logic [8:0] BO_LIM = 9'h0ff;
	localparam logic [8:0] CNT_SAT = 9'h1ff;
	localparam logic [31:0] W3_MASK = 32'h0000_ffff;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_SLV = 2'b10;
	localparam logic [9:0] CKS_MUL = 10'h004;
	localparam int TQ_MIN = 8;
	localparam int TQ_MAX = 25;
	typedef enum logic {TX_IDLE = 1'b0, TX_BUSY = 1'b1} tx_state_t;
endpackage

// ==== can_buf_timing.sv ====
// CAN receive/transmit buffer control, error status and bit timing
//
// Operation
// - Two masks; zero mask bit always matches.
// - Overrun sets overrun and error flags, drops.
// - Without double buffering, buffers stay independent.
// - Double buffering diverts buffer-zero message to one.
// - Receive errors increment receive counter; error flag only via warning.
// - Receive counter at 96 sets warning.
// - Loaded message sets that buffer's received flag.
// - Wake event sets wake-up flag.
// - Any receive error sets invalid-message flag.
// - Receive counter above 127 sets passive flag.
// - Three transmit buffers of fourteen bytes.
// - Two-bit priority, 11 highest, picks winner.
// - Winner re-evaluated every cycle until start.
// - Setting request clears aborted, lost, error flags.
// - Success clears request, sets free flag if enabled.
// - Failure keeps request, sets error or lost.
// - Clear request or abort-all aborts, sets aborted.
// - Transmit errors count; above 96 sets warning.
// - Free flag marks buffer available again.
// - Above 127 passive, above 255 bus-off.
// - Bit time is sync plus three segments.
// - Quantum prescaler 1..64, clock select divides input by four.
// - Quantum equals 2*(field+1) input clocks.
// - Only hardware sets received; software clears.
`timescale 1ns/1ps
module can_buf_timing (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [can_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [can_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic rx_msg_valid,
	input wire logic [28:0] rx_msg_id,
	input wire logic rx_err,
	input wire logic wake_event,
	input wire logic tx_start,
	input wire logic tx_ok,
	input wire logic tx_err,
	input wire logic tx_lost,
	input wire logic [1:0] tx_rd_word,
	output logic tx_pending,
	output logic [1:0] tx_sel,
	output logic [31:0] tx_rd_data,
	output logic tq_tick,
	output logic bit_tick,
	output logic bus_off
);
	import can_pkg::*;

	logic aw_ff, w_ff, bvalid_ff, rvalid_ff, arready_ff, awready_ff, wready_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, wmask, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic do_wr, wr_hit, abort_all_pending_wr;
	logic [1:0] ctrl_ff;
	logic [31:0] tim_ff, filt0_ff, filt1_ff, mask0_ff, mask1_ff;
	logic [28:0] rxid0_ff, rxid1_ff;
	logic [15:0] stat_ff, nxt_set;
	logic [8:0] rxcnt_ff, txcnt_ff;
	logic [6:0] txcon_ff [3];
	logic [2:0] abt_pend_ff;
	logic [31:0] txmem [12];
	tx_state_t txst_ff;
	logic [1:0] act_ff, nxt_sel, tx_sel_ff;
	logic tx_pending_ff, bus_off_ff, tq_ff, bit_ff;
	logic [31:0] tx_rd_ff;
	logic m0, m1, ld0, ld1, ovr0, ovr1;
	logic [9:0] presc_ff, period;
	logic [4:0] tq_cnt_ff, bit_len;

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign tx_pending = tx_pending_ff;
	assign tx_sel = tx_sel_ff;
	assign tx_rd_data = tx_rd_ff;
	assign tq_tick = tq_ff;
	assign bit_tick = bit_ff;
	assign bus_off = bus_off_ff;

	assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	assign do_wr = aw_ff && w_ff && !bvalid_ff;
	assign wr_hit = (awaddr_ff <= A_RECEIVE_BUFFER_ONE) || (awaddr_ff >= A_TXB && awaddr_ff <= A_TXB_END);
	assign abort_all_pending_wr = do_wr && awaddr_ff == A_CTRL && wstrb_ff[1] && wdata_ff[CTRL_ABORT_ALL_PENDING];

	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OK;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			if (awvalid && !aw_ff) begin
				aw_ff <= 1'b1;
				awready_ff <= 1'b0;
				awaddr_ff <= awaddr;
			end
			if (wvalid && !w_ff) begin
				w_ff <= 1'b1;
				wready_ff <= 1'b0;
				wdata_ff <= wdata;
				wstrb_ff <= wstrb;
			end
			if (do_wr) begin
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff <= 1'b1;
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? RESP_OK : RESP_SLV;
			end else if (bvalid_ff && bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// Configuration registers and transmit buffer storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= 2'b00;
			tim_ff <= 32'h0000_0000;
			filt0_ff <= 32'h0000_0000;
			filt1_ff <= 32'h0000_0000;
			mask0_ff <= 32'h0000_0000;
			mask1_ff <= 32'h0000_0000;
		end else if (do_wr) begin
			if (awaddr_ff == A_CTRL && wstrb_ff[0]) begin
				ctrl_ff <= wdata_ff[1:0];
			end else if (awaddr_ff == A_TIM) begin
				tim_ff <= ((tim_ff & ~wmask) | (wdata_ff & wmask)) & TIM_MASK;
			end else if (awaddr_ff == A_FILT0) begin
				filt0_ff <= (filt0_ff & ~wmask) | (wdata_ff & wmask);
			end else if (awaddr_ff == A_FILT1) begin
				filt1_ff <= (filt1_ff & ~wmask) | (wdata_ff & wmask);
			end else if (awaddr_ff == A_MASK0) begin
				mask0_ff <= (mask0_ff & ~wmask) | (wdata_ff & wmask);
			end else if (awaddr_ff == A_MASK1) begin
				mask1_ff <= (mask1_ff & ~wmask) | (wdata_ff & wmask);
			end
		end
	end

	// three buffers, last word holds two bytes
	always_ff @(posedge aclk) begin
		if (do_wr && awaddr_ff >= A_TXB && awaddr_ff <= A_TXB_END) begin
			txmem[awaddr_ff[5:2]] <= ((txmem[awaddr_ff[5:2]] & ~wmask) | (wdata_ff & wmask))
				& ((awaddr_ff[3:2] == 2'b11) ? W3_MASK : 32'hffff_ffff);
		end
		tx_rd_ff <= txmem[{act_ff, tx_rd_word}];
	end

	assign m0 = ((rx_msg_id ^ filt0_ff[28:0]) & mask0_ff[28:0]) == 29'h0;
	assign m1 = ((rx_msg_id ^ filt1_ff[28:0]) & mask1_ff[28:0]) == 29'h0;

	always_comb begin
		ld0 = 1'b0;
		ld1 = 1'b0;
		ovr0 = 1'b0;
		ovr1 = 1'b0;
		if (rx_msg_valid && m0) begin
			if (!stat_ff[F_RX0]) begin
				ld0 = 1'b1;
			end else if (ctrl_ff[CTRL_DOUBLE_BUFFER_ENABLE]) begin
				ld1 = !stat_ff[F_RX1];
				ovr1 = stat_ff[F_RX1];
			end else begin
				ovr0 = 1'b1;
			end
		end else if (rx_msg_valid && m1) begin
			ld1 = !stat_ff[F_RX1];
			ovr1 = stat_ff[F_RX1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxid0_ff <= 29'h0;
			rxid1_ff <= 29'h0;
		end else begin
			if (ld0) begin
				rxid0_ff <= rx_msg_id;
			end
			if (ld1) begin
				rxid1_ff <= rx_msg_id;
			end
		end
	end

	// Hardware flag sources
	always_comb begin
		nxt_set = 16'h0000;
		nxt_set[F_RX0] = ld0;
		nxt_set[F_RX1] = ld1;
		nxt_set[F_OVR0] = ovr0;
		nxt_set[F_OVR1] = ovr1;
		nxt_set[F_WAK] = wake_event;
		nxt_set[F_IVR] = rx_err;
		nxt_set[F_RX_WARNING_FLAG] = rxcnt_ff >= WARN_LIM;
		nxt_set[F_RX_ERROR_PASSIVE_FLAG] = rxcnt_ff > PASS_LIM;
		nxt_set[F_TX_WARNING_FLAG] = txcnt_ff > WARN_LIM;
		nxt_set[F_TX_ERROR_PASSIVE_FLAG] = txcnt_ff > PASS_LIM;
		nxt_set[F_BO] = txcnt_ff > BO_LIM;
		if (txst_ff == TX_BUSY && tx_ok && txcon_ff[act_ff][C_IE]) begin
			nxt_set[F_TX0 + 32'(act_ff)] = 1'b1;
		end
		// receive errors raise the error flag only through the receive warning
		nxt_set[F_ERR] = ovr0 || ovr1 || nxt_set[F_RX_WARNING_FLAG] || nxt_set[F_TX_WARNING_FLAG] || nxt_set[F_TX_ERROR_PASSIVE_FLAG] || nxt_set[F_BO];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_ff <= 16'h0000;
		end else if (do_wr && awaddr_ff == A_INTF) begin
			stat_ff <= (stat_ff & ~(wdata_ff[15:0] & wmask[15:0])) | nxt_set;
		end else begin
			stat_ff <= stat_ff | nxt_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxcnt_ff <= 9'h000;
		end else if (rx_err && rxcnt_ff < BO_LIM) begin
			rxcnt_ff <= rxcnt_ff + 9'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txcnt_ff <= 9'h000;
		end else if (txst_ff == TX_BUSY && tx_err && txcnt_ff < CNT_SAT) begin
			txcnt_ff <= txcnt_ff + 9'h001;
		end
	end

	always_comb begin
		nxt_sel = 2'd0;
		for (int n = 2; n >= 0; n--) begin
			if (txcon_ff[n][C_REQ] && !abt_pend_ff[n] && (!txcon_ff[nxt_sel][C_REQ] ||
				abt_pend_ff[nxt_sel] || txcon_ff[n][1:0] >= txcon_ff[nxt_sel][1:0])) begin
				nxt_sel = 2'(n);
			end
		end
	end

	// Transmit scheduling toward the protocol engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txst_ff <= TX_IDLE;
			act_ff <= 2'd0;
			tx_sel_ff <= 2'd0;
			tx_pending_ff <= 1'b0;
			bus_off_ff <= 1'b0;
		end else begin
			if (txst_ff == TX_IDLE) begin
				tx_sel_ff <= nxt_sel;
			end
			tx_pending_ff <= txst_ff == TX_IDLE && !tx_start && txcon_ff[nxt_sel][C_REQ]
				&& !abt_pend_ff[nxt_sel] && !stat_ff[F_BO];
			bus_off_ff <= stat_ff[F_BO];
			case (txst_ff)
				TX_IDLE: begin
					if (tx_start && tx_pending_ff) begin
						txst_ff <= TX_BUSY;
						act_ff <= tx_sel_ff;
					end
				end
				TX_BUSY: begin
					if (tx_ok || tx_err || tx_lost) begin
						txst_ff <= TX_IDLE;
					end
				end
				default: txst_ff <= TX_IDLE;
			endcase
		end
	end

	// Per-buffer transmit control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			abt_pend_ff <= 3'b000;
			for (int n = 0; n < 3; n++) begin
				txcon_ff[n] <= 7'h00;
			end
		end else begin
			for (int n = 0; n < 3; n++) begin
				if (do_wr && awaddr_ff == A_TXCON0 + 8'(4 * n) && wstrb_ff[0]) begin
					txcon_ff[n][1:0] <= wdata_ff[1:0];
					txcon_ff[n][C_IE] <= wdata_ff[C_IE];
					if (wdata_ff[C_REQ]) begin
						txcon_ff[n][C_REQ] <= 1'b1;
						txcon_ff[n][C_ERR] <= 1'b0;
						txcon_ff[n][C_LARB] <= 1'b0;
						txcon_ff[n][C_ABT] <= 1'b0;
					end
				end
				// abort unless already on the bus
				if (txcon_ff[n][C_REQ] && (abort_all_pending_wr || (do_wr && awaddr_ff == A_TXCON0 + 8'(4 * n)
					&& wstrb_ff[0] && !wdata_ff[C_REQ]))) begin
					if (txst_ff == TX_BUSY && act_ff == 2'(n)) begin
						abt_pend_ff[n] <= 1'b1;
					end else begin
						txcon_ff[n][C_REQ] <= 1'b0;
						txcon_ff[n][C_ABT] <= 1'b1;
					end
				end
				if (txst_ff == TX_BUSY && act_ff == 2'(n)) begin
					if (tx_ok) begin
						txcon_ff[n][C_REQ] <= 1'b0;
						abt_pend_ff[n] <= 1'b0;
					end else if (tx_err || tx_lost) begin
						txcon_ff[n][C_ERR] <= txcon_ff[n][C_ERR] | tx_err;
						txcon_ff[n][C_LARB] <= txcon_ff[n][C_LARB] | tx_lost;
						if (abt_pend_ff[n]) begin
							txcon_ff[n][C_REQ] <= 1'b0;
							txcon_ff[n][C_ABT] <= 1'b1;
							abt_pend_ff[n] <= 1'b0;
						end
					end
				end
			end
		end
	end

	// prescaler, slower input when select set
	assign period = ({4'h0, tim_ff[5:0]} + 10'h001) * (ctrl_ff[CTRL_CKS] ? CKS_MUL : 10'h001);
	// sync plus propagation and phase segments
	assign bit_len = 5'd4 + {2'b00, tim_ff[10:8]} + {2'b00, tim_ff[14:12]} + {2'b00, tim_ff[18:16]};

	// quantum is two times field plus one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			presc_ff <= 10'h000;
			tq_ff <= 1'b0;
		end else if (presc_ff >= {period[8:0], 1'b0} - 10'h001) begin
			presc_ff <= 10'h000;
			tq_ff <= 1'b1;
		end else begin
			presc_ff <= presc_ff + 10'h001;
			tq_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tq_cnt_ff <= 5'd0;
			bit_ff <= 1'b0;
		end else begin
			bit_ff <= tq_ff && tq_cnt_ff >= bit_len - 5'd1;
			if (tq_ff) begin
				tq_cnt_ff <= (tq_cnt_ff >= bit_len - 5'd1) ? 5'd0 : tq_cnt_ff + 5'd1;
			end
		end
	end

	// Read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= RESP_OK;
		end else begin
			arready_ff <= !rvalid_ff && !arready_ff;
			if (arvalid && arready_ff) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= RESP_OK;
				rdata_ff <= 32'h0000_0000;
				if (araddr == A_CTRL) begin
					rdata_ff[1:0] <= ctrl_ff;
				end else if (araddr == A_TIM) begin
					rdata_ff <= tim_ff;
				end else if (araddr == A_INTF) begin
					rdata_ff[15:0] <= stat_ff;
				end else if (araddr == A_ERRCNT) begin
					rdata_ff[24:0] <= {txcnt_ff, 8'h00, rxcnt_ff[7:0]};
				end else if (araddr == A_FILT0) begin
					rdata_ff <= filt0_ff;
				end else if (araddr == A_FILT1) begin
					rdata_ff <= filt1_ff;
				end else if (araddr == A_MASK0) begin
					rdata_ff <= mask0_ff;
				end else if (araddr == A_MASK1) begin
					rdata_ff <= mask1_ff;
				end else if (araddr >= A_TXCON0 && araddr < A_TXCON0 + 8'h0c) begin
					rdata_ff[6:0] <= txcon_ff[araddr[3:2]];
				end else if (araddr == A_RECEIVE_BUFFER_ZERO) begin
					rdata_ff[28:0] <= rxid0_ff;
				end else if (araddr == A_RECEIVE_BUFFER_ONE) begin
					rdata_ff[28:0] <= rxid1_ff;
				end else if (araddr >= A_TXB && araddr <= A_TXB_END) begin
					rdata_ff <= txmem[araddr[5:2]];
				end else begin
					rresp_ff <= RESP_SLV;
				end
			end else if (rvalid_ff && rready) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	property p_rxcnt;
		@(posedge aclk) disable iff (!aresetn) rx_err && rxcnt_ff < BO_LIM |=> rxcnt_ff == $past(rxcnt_ff) + 9'h001;
	endproperty
	a_rxcnt: assert property (p_rxcnt) else $error("receive counter not incremented");
	property p_rx_warning_flag;
		@(posedge aclk) disable iff (!aresetn) rxcnt_ff == WARN_LIM |=> stat_ff[F_RX_WARNING_FLAG] && stat_ff[F_ERR];
	endproperty
	a_rx_warning_flag: assert property (p_rx_warning_flag) else $error("receive warning missing");
	property p_rx_error_passive_flag;
		@(posedge aclk) disable iff (!aresetn) rxcnt_ff > PASS_LIM |=> stat_ff[F_RX_ERROR_PASSIVE_FLAG];
	endproperty
	a_rx_error_passive_flag: assert property (p_rx_error_passive_flag) else $error("receive passive missing");
	property p_ovr0;
		@(posedge aclk) disable iff (!aresetn) rx_msg_valid && m0 && stat_ff[F_RX0] && !ctrl_ff[CTRL_DOUBLE_BUFFER_ENABLE]
			|=> stat_ff[F_OVR0] && stat_ff[F_ERR] && rxid0_ff == $past(rxid0_ff);
	endproperty
	a_ovr0: assert property (p_ovr0) else $error("overrun not flagged");
	property p_dbl;
		@(posedge aclk) disable iff (!aresetn) rx_msg_valid && m0 && stat_ff[F_RX0] && !stat_ff[F_RX1]
			&& ctrl_ff[CTRL_DOUBLE_BUFFER_ENABLE] |=> stat_ff[F_RX1] && rxid1_ff == $past(rx_msg_id);
	endproperty
	a_dbl: assert property (p_dbl) else $error("double buffer divert failed");
	property p_txok;
		@(posedge aclk) disable iff (!aresetn) txst_ff == TX_BUSY && tx_ok |=> !txcon_ff[$past(act_ff)][C_REQ] ##1 txst_ff == TX_IDLE;
	endproperty
	a_txok: assert property (p_txok) else $error("request not cleared on success");
	property p_lost;
		@(posedge aclk) disable iff (!aresetn) txst_ff == TX_BUSY && tx_lost && !tx_ok && !abt_pend_ff[act_ff]
			|=> txcon_ff[$past(act_ff)][C_REQ] && txcon_ff[$past(act_ff)][C_LARB];
	endproperty
	a_lost: assert property (p_lost) else $error("lost arbitration handling wrong");
	property p_tx_warning_flag;
		@(posedge aclk) disable iff (!aresetn) txcnt_ff > WARN_LIM |=> stat_ff[F_TX_WARNING_FLAG] && stat_ff[F_ERR];
	endproperty
	a_tx_warning_flag: assert property (p_tx_warning_flag) else $error("transmit warning missing");
	property p_bo;
		@(posedge aclk) disable iff (!aresetn) txcnt_ff > BO_LIM |-> ##2 bus_off_ff && !tx_pending_ff;
	endproperty
	a_bo: assert property (p_bo) else $error("bus-off not entered");
	property p_tq;
		@(posedge aclk) disable iff (!aresetn) tq_ff |=> !tq_ff;
	endproperty
	a_tq: assert property (p_tq) else $error("quantum shorter than two clocks");
	c_load: cover property (@(posedge aclk) disable iff (!aresetn) ld1 && rx_msg_valid && m0);
	c_send: cover property (@(posedge aclk) disable iff (!aresetn) txst_ff == TX_BUSY && tx_ok);
	c_abort: cover property (@(posedge aclk) disable iff (!aresetn) abort_all_pending_wr && txst_ff == TX_IDLE);
	c_bit: cover property (@(posedge aclk) disable iff (!aresetn) bit_ff);
endmodule

// ==== can_engine_model.sv ====
// Behavioural CAN protocol engine on the bus side of the block
`timescale 1ns/1ps
module can_engine_model (
	input wire logic aclk,
	input wire logic tx_pending,
	input wire logic [31:0] tx_rd_data,
	output logic rx_msg_valid,
	output logic [28:0] rx_msg_id,
	output logic rx_err,
	output logic wake_event,
	output logic tx_start,
	output logic tx_ok,
	output logic tx_err,
	output logic tx_lost,
	output logic [1:0] tx_rd_word
);
	initial begin
		{rx_msg_valid, rx_msg_id, rx_err, wake_event, tx_start, tx_ok, tx_err, tx_lost, tx_rd_word} = '0;
	end
	task automatic rx_msg(input logic [28:0] id);
		@(posedge aclk);
		rx_msg_valid <= 1'b1;
		rx_msg_id <= id;
		@(posedge aclk);
		rx_msg_valid <= 1'b0;
		rx_msg_id <= ~id;
	endtask
	task automatic pulse(input bit wk, input int n);
		repeat (n) begin
			@(posedge aclk);
			{wake_event, rx_err} <= wk ? 2'b10 : 2'b01;
			@(posedge aclk);
			{wake_event, rx_err} <= 2'b00;
		end
	endtask
	task automatic tx_try(input logic [1:0] kind, input int dly, input logic [1:0] w, output logic [31:0] d);
		repeat (2) @(posedge aclk);
		while (tx_pending !== 1'b1) @(posedge aclk);
		tx_start <= 1'b1;
		tx_rd_word <= w;
		@(posedge aclk);
		tx_start <= 1'b0;
		repeat (dly) @(posedge aclk);
		d = tx_rd_data;
		{tx_lost, tx_err, tx_ok} <= 3'b001 << kind;
		@(posedge aclk);
		{tx_lost, tx_err, tx_ok} <= 3'b000;
	endtask
endmodule

// ==== can_buf_timing_tb.sv ====
// Self-checking testbench for the CAN buffer, status and bit timing block
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module can_buf_timing_tb;
	import can_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, tq_tick, bit_tick, bus_off, tx_pending;
	logic [1:0] bresp, rresp, tx_sel, tx_rd_word;
	logic [31:0] rdata, tx_rd_data;
	logic rx_msg_valid, rx_err, wake_event, tx_start, tx_ok, tx_err, tx_lost;
	logic [28:0] rx_msg_id;
	int fails = 0;
	int comparisons = 0;
	always #2.5 aclk = ~aclk;
	can_buf_timing i_can_buf_timing (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.rx_msg_valid, .rx_msg_id, .rx_err, .wake_event, .tx_start, .tx_ok, .tx_err, .tx_lost, .tx_rd_word,
		.tx_pending, .tx_sel, .tx_rd_data, .tq_tick, .bit_tick, .bus_off);
	can_engine_model i_can_engine_model (.aclk, .tx_pending, .tx_rd_data, .rx_msg_valid, .rx_msg_id, .rx_err,
		.wake_event, .tx_start, .tx_ok, .tx_err, .tx_lost, .tx_rd_word);
	task automatic wrap_up;
		if (fails == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OK,
		input logic [3:0] s = 4'hf);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		{awvalid, wvalid, bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, r)
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK(d & m, e)
		`CHK(r, RESP_OK)
	endtask
	task automatic gap(input bit b, output int n);
		int k;
		repeat (2) begin
			n = 0;
			for (k = 0; k < 4000; k++) begin
				@(posedge aclk);
				n++;
				if ((b ? bit_tick : tq_tick) === 1'b1) break;
			end
		end
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		chk_rd(A_INTF, '1, 32'h0);
		chk_rd(A_ERRCNT, '1, 32'h0);
		rd(8'h80, d, r);
		`CHK(r, RESP_SLV)
		wr(8'h80, 32'h1, RESP_SLV);
		wr(A_TXB + 8'h2c, '1);
		chk_rd(A_TXB + 8'h2c, '1, W3_MASK);
	endtask
	task automatic t_filter;
		wr(A_MASK0, 32'h1);
		wr(A_FILT0, 32'h0);
		wr(A_MASK1, 32'h1fff_ffff);
		wr(A_FILT1, 32'h0abc_def1);
		i_can_engine_model.rx_msg(29'h0abc_def1);
		chk_rd(A_INTF, 32'h3, 32'h2);
		chk_rd(A_RECEIVE_BUFFER_ONE, 32'h1fff_ffff, 32'h0abc_def1);
		i_can_engine_model.rx_msg(29'h1555_5554);
		chk_rd(A_INTF, 32'h3, 32'h3);
		chk_rd(A_RECEIVE_BUFFER_ZERO, 32'h1fff_ffff, 32'h1555_5554);
		wr(A_INTF, '1);
		chk_rd(A_INTF, 32'h3, 32'h0);
	endtask
	task automatic t_overrun;
		i_can_engine_model.rx_msg(29'h2);
		i_can_engine_model.rx_msg(29'h4);
		chk_rd(A_INTF, 32'hc023, 32'h8021);
		chk_rd(A_RECEIVE_BUFFER_ZERO, 32'h1fff_ffff, 32'h2);
		wr(A_INTF, '1);
		wr(A_CTRL, 32'h1);
		i_can_engine_model.rx_msg(29'h6);
		i_can_engine_model.rx_msg(29'h8);
		chk_rd(A_INTF, 32'hc023, 32'h0003);
		chk_rd(A_RECEIVE_BUFFER_ONE, 32'h1fff_ffff, 32'h8);
		i_can_engine_model.rx_msg(29'ha);
		chk_rd(A_INTF, 32'hc023, 32'h4023);
		chk_rd(A_INTF, 32'hc023, 32'h4023);
		wr(A_INTF, '1);
		wr(A_CTRL, 32'h0);
	endtask
	task automatic t_rx_err;
		i_can_engine_model.pulse(1'b0, 95);
		chk_rd(A_ERRCNT, 32'hff, 32'd95);
		chk_rd(A_INTF, 32'haa0, 32'h080);
		i_can_engine_model.pulse(1'b0, 1);
		chk_rd(A_INTF, 32'ha80, 32'h280);
		i_can_engine_model.pulse(1'b0, 31);
		chk_rd(A_INTF, 32'h800, 32'h0);
		i_can_engine_model.pulse(1'b0, 1);
		chk_rd(A_INTF, 32'h800, 32'h800);
		i_can_engine_model.pulse(1'b1, 1);
		chk_rd(A_INTF, 32'h40, 32'h40);
	endtask
	task automatic t_tx;
		logic [31:0] d;
		wr(A_INTF, '1);
		wr(A_TXB, 32'hcafe_0123);
		wr(A_TXCON0, 32'h0d);
		wr(A_TXCON0 + 8'h4, 32'h0b);
		wr(A_TXCON0 + 8'h8, 32'h0a);
		chk_rd(A_TXCON0 + 8'h4, 32'h7f, 32'h0b);
		`CHK(tx_sel, 2'd1)
		wr(A_TXCON0, 32'h0f);
		repeat (2) @(posedge aclk);
		`CHK(tx_sel, 2'd0)
		i_can_engine_model.tx_try(2'd2, 20, 2'd0, d);
		`CHK(d, 32'hcafe_0123)
		chk_rd(A_TXCON0, 32'h7f, 32'h2f);
		chk_rd(A_INTF, 32'h1c, 32'h0);
		wr(A_TXCON0, 32'h0f);
		chk_rd(A_TXCON0, 32'h7f, 32'h0f);
		i_can_engine_model.tx_try(2'd0, 2, 2'd0, d);
		chk_rd(A_TXCON0, 32'h7f, 32'h07);
		chk_rd(A_INTF, 32'h1c, 32'h04);
		i_can_engine_model.tx_try(2'd1, 2, 2'd0, d);
		chk_rd(A_TXCON0 + 8'h4, 32'h7f, 32'h1b);
		chk_rd(A_ERRCNT, 32'h01ff_0000, 32'h0001_0000);
		wr(A_TXCON0 + 8'h4, 32'h03);
		chk_rd(A_TXCON0 + 8'h4, 32'h48, 32'h40);
		wr(A_CTRL, 32'h1000);
		chk_rd(A_TXCON0 + 8'h8, 32'h48, 32'h40);
		chk_rd(A_INTF, 32'h18, 32'h0);
		`CHK(tx_pending, 1'b0)
	endtask
	task automatic t_tx_cnt;
		logic [31:0] d;
		int i;
		wr(A_TXCON0 + 8'h8, 32'h0a);
		for (i = 2; i <= 256; i++) begin
			i_can_engine_model.tx_try(2'd1, 2, 2'd3, d);
			if (i == 96 || i == 97 || i == 127 || i == 128 || i == 255 || i == 256) begin
				chk_rd(A_ERRCNT, 32'h01ff_0000, 32'(i) << 16);
				chk_rd(A_INTF, 32'h3400, {18'h0, i > 255, i > 127, 1'b0, i > 96, 10'h0});
				`CHK(bus_off, i > 255)
			end
		end
		`CHK(d, W3_MASK)
	endtask
	task automatic t_timing;
		int n;
		wr(A_TIM, 32'h0001_2101);
		chk_rd(A_TIM, '1, 32'h0001_2101);
		wr(A_TIM, 32'hffff_ffff, RESP_OK, 4'h4);
		chk_rd(A_TIM, '1, 32'h0007_2101);
		gap(1'b0, n);
		`CHK(n, 4)
		gap(1'b1, n);
		`CHK(n, 56)
		wr(A_CTRL, 32'h2);
		gap(1'b0, n);
		`CHK(n, 16)
		wr(A_CTRL, 32'h0);
		wr(A_TIM, 32'h0007_773f);
		gap(1'b0, n);
		`CHK(n, 128)
		gap(1'b1, n);
		`CHK(n, 3200)
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_filter;
		t_overrun;
		t_rx_err;
		t_tx;
		t_tx_cnt;
		t_timing;
		wrap_up;
	end
	initial begin
		#300000;
		fails++;
		wrap_up;
	end
endmodule
